// File: core/ssvs_pkg.sv
// Constants and types for the synthesizer status and oscillator select block
package ssvs_pkg;

  // Byte offsets on the register bus
  localparam logic [4:0] OFF_CFG0     = 5'h00;
  localparam logic [4:0] OFF_CFG1     = 5'h04;
  localparam logic [4:0] OFF_STATUS   = 5'h08;
  localparam logic [4:0] OFF_IRQ_STS  = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

  // Configuration word 0 fields
  localparam int STSEL_LSB = 29;
  localparam int STSEL_MSB = 31;
  localparam int TX_MODE_BIT = 27;
  // Configuration word 1 fields
  localparam int HALVE_BIT    = 18;
  localparam int BIAS_LSB     = 19;
  localparam int BIAS_MSB     = 22;
  localparam int RECENTRE_LSB = 23;
  localparam int RECENTRE_MSB = 24;
  localparam int TANK_BIT     = 25;

  // Reset values
  localparam logic [31:0] CFG0_RESET     = 32'h0000_0000;
  localparam logic [31:0] CFG1_RESET     = 32'h0010_0000;
  localparam logic [3:0]  IRQ_MASK_RESET = 4'h0;

  // Status output selection codes
  localparam logic [2:0] SEL_SUPPLY = 3'h0;
  localparam logic [2:0] SEL_CAL    = 3'h1;
  localparam logic [2:0] SEL_LOCK   = 3'h2;
  localparam logic [2:0] SEL_RSSI   = 3'h3;
  localparam logic [2:0] SEL_TRX    = 3'h4;

  // Interrupt bit positions
  localparam int IRQ_CAL_DONE = 0;
  localparam int IRQ_LOCK_SET = 1;
  localparam int IRQ_LOCK_LOST = 2;
  localparam int IRQ_RSSI = 3;

  // Lock detect thresholds in ns and qualifying run length
  localparam logic [7:0] LOCK_SET_NS   = 8'h0f;
  localparam logic [7:0] LOCK_CLEAR_NS = 8'h19;
  localparam logic [2:0] LOCK_RUN      = 3'h5;

  typedef enum logic [0:0] {
    LOCK_OFF = 1'b0,
    LOCK_ON  = 1'b1
  } ssvs_lock_e;

  typedef struct packed {
    logic [31:0] cfg0;
    logic [31:0] cfg1;
    logic [3:0]  irq_sts;
    logic [3:0]  irq_mask;
    logic        ack;
    logic [31:0] rdata;
    ssvs_lock_e  lock;
    logic [2:0]  lock_cnt;
    logic        cal_done_p;
    logic        rssi_p;
    logic        carrier;
    logic        halved;
    logic        rf;
    logic        status_pin;
    logic        trx;
  } ssvs_state_s;

endpackage : ssvs_pkg

// File: core/ssvs_top.sv
// Status pin multiplexer, lock detect and oscillator selection decode
//
// Function
// - Calibration-done indicator is low during coarse and fine filter calibration.
// - Lock flag sets after five consecutive comparisons below 15 ns error.
// - Lock flag stays set until one comparison shows 25 ns error or more, or word 0 or word 1 is written.
// - Signal-strength settled goes high when measurement settled; host waits.
// - Transmit/receive indicator low in transmit, high in receive.
// - Tank select bit 25 of word 1, zero by default, selects internal core.
// - Tank select one switches to external-inductor lower-band core.
// - Two-bit recentre field shifts oscillator range by at most one percent.
// - Both cores run at twice RF; fixed divide-by-two in the loop.
// - Halving bit 18 adds a further divide-by-two outside the loop.
// - Word 0 bits 29 to 31 choose the indicator on the status pin.
// - Status pin selection defaults to supply settled after power-up.
`timescale 1ns/1ps

module ssvs_top (
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             irq,
  // Analogue side indications
  input  wire logic        supply_settled_flag,
  input  wire logic        cal_coarse_active,
  input  wire logic        cal_fine_active,
  input  wire logic        rssi_settled_in,
  input  wire logic        pd_cmp_valid,
  input  wire logic [7:0]  pd_phase_err_ns,
  input  wire logic        osc_tick,
  // Pins and oscillator controls
  output logic             status_output_pin,
  output logic             transmit_receive_indicator,
  output logic             synth_lock_flag,
  output logic             oscillator_tank_select,
  output logic [3:0]       oscillator_bias_level,
  output logic [1:0]       oscillator_recentre,
  output logic             output_halving_select,
  output logic             rf_divided_out
);

  ssvs_pkg::ssvs_state_s st_q;
  ssvs_pkg::ssvs_state_s st_d;

  logic        acc_wr;
  logic        reprogram;
  logic        cal_done;
  logic        lock_good;
  logic        lock_bad;
  logic [3:0]  irq_set;
  logic [3:0]  irq_clr;
  logic [2:0]  sel;
  logic [4:0]  status_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] ssvs_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : ssvs_merge

  function automatic logic ssvs_pick(
    input logic [2:0] s,
    input logic [4:0] v
  );
    logic r;
    r = 1'b0;
    case (s)
      ssvs_pkg::SEL_SUPPLY: r = v[0];
      ssvs_pkg::SEL_CAL:    r = v[1];
      ssvs_pkg::SEL_LOCK:   r = v[2];
      ssvs_pkg::SEL_RSSI:   r = v[3];
      ssvs_pkg::SEL_TRX:    r = v[4];
      default:              r = 1'b0;
    endcase
    return r;
  endfunction : ssvs_pick

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Write lands only on the edge where waitrequest is low
  assign acc_wr    = write && st_q.ack;
  assign reprogram = acc_wr && (address == ssvs_pkg::OFF_CFG0 ||
                                address == ssvs_pkg::OFF_CFG1);
  assign cal_done  = !(cal_coarse_active || cal_fine_active);
  assign lock_good = pd_cmp_valid &&
                     (pd_phase_err_ns < ssvs_pkg::LOCK_SET_NS);
  assign lock_bad  = pd_cmp_valid &&
                     (pd_phase_err_ns >= ssvs_pkg::LOCK_CLEAR_NS);
  assign sel       = st_q.cfg0[ssvs_pkg::STSEL_MSB:ssvs_pkg::STSEL_LSB];
  assign status_vec = {st_q.trx, rssi_settled_in, st_q.lock == ssvs_pkg::LOCK_ON,
                       cal_done, supply_settled_flag};

  always_comb begin
    irq_set = 4'h0;
    irq_set[ssvs_pkg::IRQ_CAL_DONE]  = cal_done && !st_q.cal_done_p;
    irq_set[ssvs_pkg::IRQ_LOCK_SET]  = (st_d.lock == ssvs_pkg::LOCK_ON) &&
                                       (st_q.lock == ssvs_pkg::LOCK_OFF);
    irq_set[ssvs_pkg::IRQ_LOCK_LOST] = (st_d.lock == ssvs_pkg::LOCK_OFF) &&
                                       (st_q.lock == ssvs_pkg::LOCK_ON);
    irq_set[ssvs_pkg::IRQ_RSSI]      = rssi_settled_in && !st_q.rssi_p;
    irq_clr = (acc_wr && address == ssvs_pkg::OFF_IRQ_STS) ?
              writedata[3:0] : 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d = st_q;
    // One wait cycle per access, answer stands for exactly one edge
    st_d.ack   = (read || write) && !st_q.ack;
    st_d.rdata = 32'h0000_0000;
    if (read && !st_q.ack) begin
      case (address)
        ssvs_pkg::OFF_CFG0:     st_d.rdata = st_q.cfg0;
        ssvs_pkg::OFF_CFG1:     st_d.rdata = st_q.cfg1;
        ssvs_pkg::OFF_STATUS:   st_d.rdata = {27'h0, status_vec};
        ssvs_pkg::OFF_IRQ_STS:  st_d.rdata = {28'h0, st_q.irq_sts};
        ssvs_pkg::OFF_IRQ_MASK: st_d.rdata = {28'h0, st_q.irq_mask};
        default:                st_d.rdata = 32'h0000_0000;
      endcase
    end
    if (acc_wr) begin
      case (address)
        ssvs_pkg::OFF_CFG0: begin
          st_d.cfg0 = ssvs_merge(st_q.cfg0, writedata, byteenable);
        end
        ssvs_pkg::OFF_CFG1: begin
          st_d.cfg1 = ssvs_merge(st_q.cfg1, writedata, byteenable);
        end
        ssvs_pkg::OFF_IRQ_MASK: begin
          if (byteenable[0]) begin
            st_d.irq_mask = writedata[3:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Set wins over a same-cycle write-one-to-clear
    st_d.irq_sts = (st_q.irq_sts & ~irq_clr) | irq_set;

    // Lock detect with hysteresis between set and clear thresholds
    case (st_q.lock)
      ssvs_pkg::LOCK_OFF: begin
        if (lock_good) begin
          if (st_q.lock_cnt == ssvs_pkg::LOCK_RUN - 3'h1) begin
            st_d.lock     = ssvs_pkg::LOCK_ON;
            st_d.lock_cnt = 3'h0;
          end else begin
            st_d.lock_cnt = st_q.lock_cnt + 3'h1;
          end
        end else if (pd_cmp_valid) begin
          st_d.lock_cnt = 3'h0;
        end
      end
      ssvs_pkg::LOCK_ON: begin
        if (lock_bad) begin
          st_d.lock = ssvs_pkg::LOCK_OFF;
        end
      end
      default: begin
        st_d.lock = ssvs_pkg::LOCK_OFF;
      end
    endcase
    if (reprogram) begin
      // Fresh qualification after any synthesizer change
      st_d.lock     = ssvs_pkg::LOCK_OFF;
      st_d.lock_cnt = 3'h0;
    end

    st_d.cal_done_p = cal_done;
    st_d.rssi_p     = rssi_settled_in;

    // Core runs at twice RF: in-loop divide by two on every oscillator tick
    if (osc_tick) begin
      st_d.carrier = !st_q.carrier;
      if (st_q.carrier) begin
        st_d.halved = !st_q.halved;
      end
    end
    st_d.rf = st_q.cfg1[ssvs_pkg::HALVE_BIT] ? st_d.halved : st_d.carrier;

    st_d.trx = !st_q.cfg0[ssvs_pkg::TX_MODE_BIT];
    st_d.status_pin = ssvs_pick(sel, status_vec);

    if (rst) begin
      st_d            = '0;
      st_d.cfg0       = ssvs_pkg::CFG0_RESET;
      st_d.cfg1       = ssvs_pkg::CFG1_RESET;
      st_d.irq_mask   = ssvs_pkg::IRQ_MASK_RESET;
      st_d.lock       = ssvs_pkg::LOCK_OFF;
      st_d.cal_done_p = 1'b1;
      st_d.trx        = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign waitrequest                = (read || write) && !st_q.ack;
  assign readdata                   = st_q.rdata;
  assign irq                        = |(st_q.irq_sts & st_q.irq_mask);
  assign status_output_pin          = st_q.status_pin;
  assign transmit_receive_indicator = st_q.trx;
  assign synth_lock_flag            = st_q.lock == ssvs_pkg::LOCK_ON;
  assign oscillator_tank_select     = st_q.cfg1[ssvs_pkg::TANK_BIT];
  assign oscillator_bias_level      =
    st_q.cfg1[ssvs_pkg::BIAS_MSB:ssvs_pkg::BIAS_LSB];
  // Code only trims the tank; analogue range limit keeps the shift small
  assign oscillator_recentre        =
    st_q.cfg1[ssvs_pkg::RECENTRE_MSB:ssvs_pkg::RECENTRE_LSB];
  assign output_halving_select      = st_q.cfg1[ssvs_pkg::HALVE_BIT];
  assign rf_divided_out             = st_q.rf;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_lock_run_five: assert property (
    $rose(synth_lock_flag) |->
      $past(lock_good) && $past(st_q.lock_cnt) == 3'h4)
    else $error("lock set without five good comparisons");

  a_lock_big_err: assert property (
    synth_lock_flag && lock_bad |=> !synth_lock_flag)
    else $error("lock held after large phase error");

  a_lock_holds: assert property (
    synth_lock_flag && !lock_bad && !reprogram |=> synth_lock_flag)
    else $error("lock dropped without cause");

  a_lock_reprog: assert property (
    reprogram |=> !synth_lock_flag && st_q.lock_cnt == 3'h0)
    else $error("lock survived reprogramming");

  a_cal_pin_low: assert property (
    sel == ssvs_pkg::SEL_CAL && !cal_done && !acc_wr |=> !status_output_pin)
    else $error("calibration indicator high during calibration");

  a_trx_level: assert property (
    st_q.cfg0[ssvs_pkg::TX_MODE_BIT] |=> !transmit_receive_indicator)
    else $error("indicator high in transmit mode");

  a_div_direct: assert property (
    osc_tick && !output_halving_select && !acc_wr
      |=> rf_divided_out != $past(rf_divided_out))
    else $error("direct output failed to toggle");

  a_div_halved: assert property (
    output_halving_select && osc_tick && !st_q.carrier && !acc_wr
      |=> rf_divided_out == $past(rf_divided_out))
    else $error("halved output toggled too early");

  a_wait_one: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered in one wait cycle");

  a_sticky_sts: assert property (
    !(acc_wr && address == ssvs_pkg::OFF_IRQ_STS)
      |=> ($past(st_q.irq_sts) & ~st_q.irq_sts) == 4'h0)
    else $error("interrupt status lost without clear");

  a_reset_dflt: assert property (
    $fell(rst) |-> sel == ssvs_pkg::SEL_SUPPLY && !oscillator_tank_select)
    else $error("wrong defaults after reset");

  c_lock_gain: cover property ($rose(synth_lock_flag));
  c_lock_loss: cover property ($fell(synth_lock_flag));
  c_cal_irq:   cover property (irq_set[ssvs_pkg::IRQ_CAL_DONE] && irq);
  c_ext_half:  cover property (oscillator_tank_select && output_halving_select);

endmodule : ssvs_top

// File: verification/ssvs_host_model.sv
// Host model watching the status pin for completion edges
`timescale 1ns/1ps

module ssvs_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic status_output_pin,
  output int       rise_cnt
);
  logic pin_q;

  // Rising pin edge taken as the calibration-done interrupt
  always @(posedge clk) begin
    pin_q <= status_output_pin;
    if (rst) begin
      rise_cnt <= 0;
    end else if (status_output_pin === 1'b1 && pin_q === 1'b0) begin
      rise_cnt <= rise_cnt + 1;
    end
  end
endmodule : ssvs_host_model

// File: verification/synth_status_and_vco_select_tb.sv
// Self-checking bench for the status pin and oscillator select block
`timescale 1ns/1ps

module synth_status_and_vco_select_tb;
  logic        clk, rst, read, write, waitrequest, irq;
  logic [4:0]  address;
  logic [3:0]  byteenable, bias;
  logic [31:0] writedata, readdata, q;
  logic        sup, cc, cf, rs, pv, ot, pin, trx, lock, tank, halve, rf;
  logic        rf_prev;
  logic [7:0]  pe;
  logic [1:0]  rec;
  logic [7:0]  rows [7] = '{8'h38, 8'h08, 8'h78, 8'h48, 8'h84, 8'h83, 8'hc2};
  logic        e;
  int          num_errors, tests_run, seed, rise_cnt, tog, c0;

  ssvs_top i_dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .supply_settled_flag(sup), .cal_coarse_active(cc),
    .cal_fine_active(cf), .rssi_settled_in(rs), .pd_cmp_valid(pv),
    .pd_phase_err_ns(pe), .osc_tick(ot), .status_output_pin(pin),
    .transmit_receive_indicator(trx), .synth_lock_flag(lock),
    .oscillator_tank_select(tank), .oscillator_bias_level(bias),
    .oscillator_recentre(rec), .output_halving_select(halve),
    .rf_divided_out(rf));

  ssvs_host_model i_host (.clk(clk), .rst(rst), .status_output_pin(pin),
    .rise_cnt(rise_cnt));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    address <= a; write <= w; read <= !w; writedata <= d;
    @(negedge clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) check("bus answer", 1'b1, 1'b0);
    rd = readdata;
    @(posedge clk);
    read <= 1'b0; write <= 1'b0;
    // Let the accepted write settle before anyone looks at outputs
    @(negedge clk);
  endtask : bus

  task automatic pulse(input logic [7:0] err);
    @(posedge clk);
    pv <= 1'b1; pe <= err;
    @(posedge clk);
    pv <= 1'b0; pe <= ~err;
    @(negedge clk);
  endtask : pulse

  task automatic run_good(input int n);
    repeat (n) pulse(8'($unsigned($random(seed)) % 15));
  endtask : run_good

  function automatic logic exp_pin(input int s);
    case (s)
      0: return sup;
      1: return !(cc | cf);
      3: return rs;
      4: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : exp_pin

  function automatic logic [31:0] cfg1_of(input logic [7:0] r);
    return (32'(r[7]) << 25) | (32'(r[6]) << 18) | (32'(r[5:4]) << 23)
           | (32'(r[3:0]) << 19);
  endfunction : cfg1_of

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk) begin
    rf_prev <= rf;
    if (rf !== rf_prev) tog++;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial begin
    seed = 32'h4a7a;
    rst = 1'b1; read = 1'b0; write = 1'b0; address = 5'h00;
    byteenable = 4'hf; writedata = 32'h0; sup = 1'b0; cc = 1'b0;
    cf = 1'b0; rs = 1'b0; pv = 1'b0; pe = 8'h00; ot = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, ssvs_pkg::OFF_CFG0, 32'h0, q);
    check("cfg0 reset", q, 32'h0);
    bus(1'b0, ssvs_pkg::OFF_CFG1, 32'h0, q);
    check("cfg1 reset", q, 32'h0010_0000);
    check("tank reset", tank, 1'b0);
    bus(1'b0, 5'h14, 32'h0, q);
    check("unmapped", q, 32'h0);
    // Select codes 0 to 5 with random indicator levels
    for (int s = 0; s < 6; s++) begin
      bus(1'b1, ssvs_pkg::OFF_CFG0, 32'(s) << 29, q);
      repeat (3) begin
        {sup, cc, cf, rs} <= 4'($random(seed));
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("status pin", pin, exp_pin(s));
      end
    end
    // Transmit mode drives the indicator low
    bus(1'b1, ssvs_pkg::OFF_CFG0, 32'h8800_0000, q);
    repeat (2) @(negedge clk);
    check("trx pin", {pin, trx}, 2'b00);
    // Calibration pulls the pin low, its end gives one rising edge
    bus(1'b1, ssvs_pkg::OFF_CFG0, 32'h2000_0000, q);
    {cc, cf} <= 2'b10;
    repeat (2) @(negedge clk);
    c0 = rise_cnt;
    cf <= 1'b1; cc <= 1'b0;
    repeat (2) @(negedge clk);
    check("cal low", pin, 1'b0);
    cf <= 1'b0;
    repeat (3) @(negedge clk);
    check("cal edges", rise_cnt - c0, 1);
    // Lock qualification, hysteresis and interrupt
    bus(1'b1, ssvs_pkg::OFF_IRQ_MASK, 32'h2, q);
    run_good(4);
    pulse(8'd15 + 8'($unsigned($random(seed)) % 10));
    check("lock broken run", lock, 1'b0);
    run_good(4);
    check("lock after 4", lock, 1'b0);
    run_good(1);
    check("lock after 5", {lock, irq}, 2'b11);
    bus(1'b0, ssvs_pkg::OFF_STATUS, 32'h0, q);
    check("status lock", q[2], 1'b1);
    pulse(8'd24);
    check("lock kept", lock, 1'b1);
    pulse(8'd25);
    check("lock lost", lock, 1'b0);
    bus(1'b1, ssvs_pkg::OFF_IRQ_STS, 32'h6, q);
    check("irq cleared", irq, 1'b0);
    run_good(5);
    bus(1'b1, ssvs_pkg::OFF_CFG1, 32'h0010_0000, q);
    check("lock on write", lock, 1'b0);
    // Host settings per band, and output division
    foreach (rows[i]) begin
      bus(1'b1, ssvs_pkg::OFF_CFG1, cfg1_of(rows[i]), q);
      check("osc fields", {tank, halve, rec, bias}, rows[i]);
      // Cleared on a rising edge, away from the negedge toggle counter
      @(posedge clk) tog = 0;
      repeat (16) @(posedge clk) ot <= ~ot;
      @(posedge clk) ot <= 1'b0;
      repeat (3) @(negedge clk);
      e = rows[i][6];
      check("rf toggles", tog, e ? 4 : 8);
    end
    final_report();
  end
endmodule : synth_status_and_vco_select_tb
